// ### sfe_pkg.sv
package sfe_pkg;

	// ****************************************
	// Instruction codes
	// ****************************************
	localparam logic [7:0] OP_FAST_READ   = 8'h0b;
	localparam logic [7:0] OP_PAGE_WRITE  = 8'h02;
	localparam logic [7:0] OP_ZONE_CLEAR  = 8'hd8;
	localparam logic [7:0] OP_WHOLE_CLEAR = 8'hc7;
	localparam logic [7:0] OP_SLEEP       = 8'hb9;
	localparam logic [7:0] OP_WAKE        = 8'hab;
	localparam logic [7:0] OP_UNLOCK      = 8'h06;

	// ****************************************
	// Frame bit counts
	// ****************************************
	localparam logic [5:0] CNT_OPCODE  = 6'h08;
	localparam logic [5:0] CNT_ADDRESS = 6'h20;
	localparam logic [5:0] CNT_DUMMY   = 6'h28;

	// ****************************************
	// Array layout
	// ****************************************
	localparam int         MEM_AW_DEF  = 19;
	localparam int         SECT_AW_DEF = 16;
	localparam int         SECT_SEL_W  = 3;
	localparam logic [7:0] ERASED      = 8'hff;
	localparam logic [7:0] PAGE_FIRST  = 8'h00;
	localparam logic [7:0] PAGE_LAST   = 8'hff;

	// ****************************************
	// Timing counts, in mclk cycles
	// ****************************************
	localparam int PROG_WAIT_DEF   = 64;
	localparam int ERASE_WAIT_DEF  = 64;
	localparam int SLEEP_DELAY_DEF = 16;
	localparam int HALF_DEF        = 4;
	localparam int GAP_DEF         = 16;

	// ****************************************
	// Bytes after the opcode, host side
	// ****************************************
	localparam logic [2:0] HDR_NONE = 3'h0;
	localparam logic [2:0] HDR_ADDR = 3'h3;
	localparam logic [2:0] HDR_FAST = 3'h4;

	// Level 0 none, level n top 2^(n-1) of 8 sectors, 4 and up all
	function automatic logic prot_hit(input logic [2:0] lvl,
		input logic [2:0] sect);
		logic [3:0] n;
		n = (lvl >= 3'h4) ? 4'h8 : (4'h1 << (lvl - 3'h1));
		return (lvl != 3'h0) && ({1'b0, sect} >= (4'h8 - n));
	endfunction

endpackage

// ### sfe_link_if.sv
`timescale 1ns/1ps
interface sfe_link_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso_o;
	logic miso_oe_n;
	logic miso;

	// Line idles high when nobody drives it
	assign miso = miso_oe_n ? 1'b1 : miso_o;

	modport dev (
		input  cs_n,
		input  sclk,
		input  mosi,
		output miso_o,
		output miso_oe_n
	);

	modport hst (
		output cs_n,
		output sclk,
		output mosi,
		input  miso
	);
endinterface

// ### sfe_device.sv
`timescale 1ns/1ps
module sfe_device #(
	parameter int MEM_AW      = sfe_pkg::MEM_AW_DEF,
	parameter int SECT_AW     = sfe_pkg::SECT_AW_DEF,
	parameter int PROG_WAIT   = sfe_pkg::PROG_WAIT_DEF,
	parameter int ERASE_WAIT  = sfe_pkg::ERASE_WAIT_DEF,
	parameter int SLEEP_DELAY = sfe_pkg::SLEEP_DELAY_DEF
) (
	// System clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Link, clocked by the host
	sfe_link_if.dev         link,
	// Protection and status
	input  wire logic [2:0] protect_level_bits,
	output logic            busy_flag,
	output logic            write_permit_latch,
	output logic            asleep
);
	import sfe_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_WAIT} sfe_state_t;
	typedef enum logic {JOB_PROG, JOB_ERASE} sfe_job_t;
	logic [7:0]        mem [0:(1 << MEM_AW) - 1];
	logic [7:0]        pbuf [0:255];
	logic [255:0]      pvalid;
	logic              link_idle, in_frame, hold_q1, hold_s;
	logic [5:0]        cnt, cnt0;
	logic [7:0]        sh, nb, opcode, wptr;
	logic [23:0]       addr;
	logic [2:0]        bpos, obit, sect;
	logic              ftag, data_bit, byte_in, rd_go, started, miso_q;
	logic [MEM_AW-1:0] raddr, rcur, wcur, wlast;
	logic              cs_q1, cs_q2, cs_q3, ftag_seen, take, ready;
	logic              dp_pend, go_unlock, go_prog, go_sect, go_bulk;
	logic              go_sleep, go_wake;
	logic [31:0]       dp_cnt, wait_cnt;
	sfe_state_t        state;
	sfe_job_t          job;

	// ****************************************
	// Link side, serial clock domain
	// ****************************************
	assign link_idle = link.cs_n | ~nrst;
	assign cnt0      = in_frame ? cnt : 6'h00;
	assign nb        = {sh[6:0], link.mosi};
	assign data_bit  = cnt0 >= CNT_ADDRESS;
	assign byte_in   = data_bit && bpos == 3'h7 &&
		opcode == OP_PAGE_WRITE && !hold_s;
	always_ff @(posedge link.sclk or posedge link_idle) begin
		if (link_idle)
			in_frame <= 1'b0;
		else
			in_frame <= 1'b1;
	end
	// Busy, asleep or sleep pending, seen from the link
	always_ff @(posedge link.sclk or negedge nrst) begin
		if (!nrst)
			{hold_s, hold_q1} <= 2'h0;
		else
			{hold_s, hold_q1} <= {hold_q1, busy_flag | asleep | dp_pend};
	end
	// Frame decode, state survives select high for the mclk side
	always_ff @(posedge link.sclk or negedge nrst) begin
		if (!nrst) begin
			cnt    <= 6'h00;
			sh     <= 8'h00;
			opcode <= 8'h00;
			addr   <= 24'h000000;
			bpos   <= 3'h0;
			wptr   <= 8'h00;
			ftag   <= 1'b0;
		end else begin
			if (!in_frame)
				ftag <= ~ftag;
			sh  <= nb;
			cnt <= (cnt0 == CNT_DUMMY) ? CNT_DUMMY : cnt0 + 6'h01;
			if (cnt0 == CNT_OPCODE - 6'h01)
				opcode <= nb;
			if (cnt0 >= CNT_OPCODE && cnt0 < CNT_ADDRESS)
				addr <= {addr[22:0], link.mosi};
			bpos <= data_bit ? bpos + 3'h1 : 3'h0;
			if (cnt0 == CNT_ADDRESS - 6'h01)
				wptr <= nb;
			else if (byte_in)
				wptr <= wptr + 8'h01;
		end
	end
	always_ff @(posedge link.sclk) begin
		if (byte_in)
			pbuf[wptr] <= nb;
	end
	// Cleared late enough that the busy view is settled
	always_ff @(posedge link.sclk or negedge nrst) begin
		if (!nrst)
			pvalid <= '0;
		else if (cnt0 == CNT_OPCODE - 6'h01 && !hold_s)
			pvalid <= '0;
		else if (byte_in)
			pvalid[wptr] <= 1'b1;
	end
	always_ff @(posedge link.sclk or posedge link_idle) begin
		if (link_idle)
			rd_go <= 1'b0;
		else if (cnt0 == CNT_DUMMY - 6'h01 &&
			opcode == OP_FAST_READ && !hold_s)
			rd_go <= 1'b1;
	end
	// Read data out, falling edges
	assign rcur = started ? raddr : addr[MEM_AW-1:0];
	always_ff @(negedge link.sclk or posedge link_idle) begin
		if (link_idle) begin
			started <= 1'b0;
			obit    <= 3'h0;
			miso_q  <= 1'b0;
			raddr   <= '0;
		end else if (rd_go) begin
			miso_q  <= mem[rcur][3'h7 - obit];
			obit    <= obit + 3'h1;
			started <= 1'b1;
			if (obit == 3'h7)
				raddr <= rcur + 1'b1;
			else
				raddr <= rcur;
		end
	end
	assign link.miso_o    = miso_q;
	assign link.miso_oe_n = ~started;

	// ****************************************
	// Command commit, system clock domain
	// ****************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			{cs_q3, cs_q2, cs_q1} <= 3'h7;
		else
			{cs_q3, cs_q2, cs_q1} <= {cs_q2, cs_q1, link.cs_n};
	end
	assign take  = cs_q2 && !cs_q3 && ftag != ftag_seen;
	assign ready = !busy_flag && !asleep && !dp_pend;
	assign sect  = addr[MEM_AW-1 -: SECT_SEL_W];
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			ftag_seen <= 1'b0;
		else if (take)
			ftag_seen <= ftag;
	end
	assign go_unlock = take && ready && opcode == OP_UNLOCK &&
		cnt == CNT_OPCODE;
	assign go_bulk = take && ready && write_permit_latch &&
		opcode == OP_WHOLE_CLEAR && cnt == CNT_OPCODE &&
		protect_level_bits == 3'h0;
	assign go_sect = take && ready && write_permit_latch &&
		opcode == OP_ZONE_CLEAR && cnt == CNT_ADDRESS &&
		!prot_hit(protect_level_bits, sect);
	assign go_prog = take && ready && write_permit_latch &&
		opcode == OP_PAGE_WRITE && cnt == CNT_DUMMY &&
		bpos == 3'h0 &&
		!prot_hit(protect_level_bits, sect);
	assign go_sleep = take && ready && opcode == OP_SLEEP &&
		cnt == CNT_OPCODE;
	assign go_wake = take && !busy_flag && asleep &&
		opcode == OP_WAKE && cnt >= CNT_OPCODE;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			write_permit_latch <= 1'b0;
		else if (go_unlock)
			write_permit_latch <= 1'b1;
		else if (state == ST_WALK && wcur == wlast)
			write_permit_latch <= 1'b0;
	end
	// Self-timed cycle: walk the range, then wait
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state    <= ST_IDLE;
			job      <= JOB_PROG;
			wcur     <= '0;
			wlast    <= '0;
			wait_cnt <= 32'h0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (go_prog) begin
					job   <= JOB_PROG;
					wcur  <= {addr[MEM_AW-1:8], PAGE_FIRST};
					wlast <= {addr[MEM_AW-1:8], PAGE_LAST};
					state <= ST_WALK;
				end else if (go_sect) begin
					job   <= JOB_ERASE;
					wcur  <= {addr[MEM_AW-1:SECT_AW], {SECT_AW{1'b0}}};
					wlast <= {addr[MEM_AW-1:SECT_AW], {SECT_AW{1'b1}}};
					state <= ST_WALK;
				end else if (go_bulk) begin
					job   <= JOB_ERASE;
					wcur  <= '0;
					wlast <= '1;
					state <= ST_WALK;
				end
			end
			ST_WALK: begin
				if (wcur == wlast) begin
					state    <= ST_WAIT;
					wait_cnt <= (job == JOB_PROG) ? PROG_WAIT : ERASE_WAIT;
				end else begin
					wcur <= wcur + 1'b1;
				end
			end
			default: begin
				if (wait_cnt == 32'h0)
					state <= ST_IDLE;
				else
					wait_cnt <= wait_cnt - 32'h1;
			end
			endcase
		end
	end
	assign busy_flag = state != ST_IDLE;
	always_ff @(posedge mclk) begin
		if (state == ST_WALK) begin
			if (job == JOB_ERASE)
				mem[wcur] <= ERASED;
			else if (pvalid[wcur[7:0]])
				mem[wcur] <= mem[wcur] & pbuf[wcur[7:0]];
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dp_pend <= 1'b0;
			dp_cnt  <= 32'h0;
			asleep  <= 1'b0;
		end else if (go_sleep) begin
			dp_pend <= 1'b1;
			dp_cnt  <= SLEEP_DELAY;
		end else if (dp_pend) begin
			if (dp_cnt == 32'h0) begin
				dp_pend <= 1'b0;
				asleep  <= 1'b1;
			end else begin
				dp_cnt <= dp_cnt - 32'h1;
			end
		end else if (go_wake) begin
			asleep <= 1'b0;
		end
	end
endmodule

// ### sfe_host.sv
`timescale 1ns/1ps
module sfe_host #(
	parameter int HALF = sfe_pkg::HALF_DEF,
	parameter int GAP  = sfe_pkg::GAP_DEF
) (
	// System clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Link to the device
	sfe_link_if.hst          link,
	// Command request
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_op,
	input  wire logic [23:0] cmd_addr,
	input  wire logic [2:0]  cmd_hdr,
	input  wire logic [15:0] cmd_wlen,
	input  wire logic [15:0] cmd_rlen,
	// Write data supply
	input  wire logic [7:0]  wr_data,
	output logic             wr_take,
	// Read data and completion
	output logic [7:0]       rd_data,
	output logic             rd_valid,
	output logic             done
);
	import sfe_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} sfe_hstate_t;

	sfe_hstate_t state;
	logic [31:0] tick;
	logic [17:0] bi;
	logic [17:0] last;
	logic [17:0] wend;
	logic [2:0]  bitn;
	logic [7:0]  obyte;
	logic [7:0]  ibyte;
	logic [7:0]  nxt;
	logic [23:0] addr;
	logic [2:0]  hdr;
	logic        cs_n;
	logic        sclk;
	logic        mosi;
	logic        miso_q1;
	logic        miso_s;
	logic        byte_end;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			miso_q1 <= 1'b1;
			miso_s  <= 1'b1;
		end else begin
			miso_q1 <= link.miso;
			miso_s  <= miso_q1;
		end
	end

	// ****************************************
	// Next byte to send
	// ****************************************
	assign byte_end = state == H_HIGH && tick == HALF - 1 && bitn == 3'h7;
	assign wr_take  = byte_end && bi != last && bi + 18'h1 > {15'h0, hdr} &&
		bi + 18'h1 <= wend;

	always_comb begin
		nxt = 8'h00;
		if (bi + 18'h1 <= {15'h0, hdr}) begin
			if (bi == 18'h0)
				nxt = addr[23:16];
			else if (bi == 18'h1)
				nxt = addr[15:8];
			else if (bi == 18'h2)
				nxt = addr[7:0];
		end else if (wr_take) begin
			nxt = wr_data;
		end
	end

	// ****************************************
	// Frame sequencer
	// ****************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state    <= H_IDLE;
			tick     <= 32'h0;
			bi       <= 18'h0;
			last     <= 18'h0;
			wend     <= 18'h0;
			bitn     <= 3'h0;
			obyte    <= 8'h00;
			ibyte    <= 8'h00;
			addr     <= 24'h000000;
			hdr      <= HDR_NONE;
			cs_n     <= 1'b1;
			sclk     <= 1'b0;
			mosi     <= 1'b0;
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
			done     <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			done     <= 1'b0;
			case (state)
			H_IDLE: begin
				if (cmd_valid) begin
					addr  <= cmd_addr;
					hdr   <= cmd_hdr;
					wend  <= {15'h0, cmd_hdr} + {2'h0, cmd_wlen};
					last  <= {15'h0, cmd_hdr} + {2'h0, cmd_wlen} +
						{2'h0, cmd_rlen};
					bi    <= 18'h0;
					bitn  <= 3'h0;
					obyte <= cmd_op;
					mosi  <= cmd_op[7];
					cs_n  <= 1'b0;
					tick  <= 32'h0;
					state <= H_LOW;
				end
			end
			H_LOW: begin
				if (tick == HALF - 1) begin
					tick  <= 32'h0;
					sclk  <= 1'b1;
					ibyte <= {ibyte[6:0], miso_s};
					state <= H_HIGH;
				end else begin
					tick <= tick + 32'h1;
				end
			end
			H_HIGH: begin
				if (tick == HALF - 1) begin
					tick <= 32'h0;
					sclk <= 1'b0;
					if (bitn == 3'h7 && bi > wend) begin
						rd_data  <= ibyte;
						rd_valid <= 1'b1;
					end
					if (bitn == 3'h7 && bi == last) begin
						cs_n  <= 1'b1;
						state <= H_GAP;
					end else if (bitn == 3'h7) begin
						bi    <= bi + 18'h1;
						bitn  <= 3'h0;
						obyte <= nxt;
						mosi  <= nxt[7];
						state <= H_LOW;
					end else begin
						bitn  <= bitn + 3'h1;
						obyte <= {obyte[6:0], 1'b0};
						mosi  <= obyte[6];
						state <= H_LOW;
					end
				end else begin
					tick <= tick + 32'h1;
				end
			end
			default: begin
				if (tick == GAP - 1) begin
					tick  <= 32'h0;
					done  <= 1'b1;
					state <= H_IDLE;
				end else begin
					tick <= tick + 32'h1;
				end
			end
			endcase
		end
	end

	assign cmd_ready = state == H_IDLE;
	assign link.cs_n = cs_n;
	assign link.sclk = sclk;
	assign link.mosi = mosi;
endmodule

// ### sfe_checker.sv
`timescale 1ns/1ps
module sfe_checker (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       nrst,
	// Link lines
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic       mosi,
	input wire logic       miso_o,
	input wire logic       miso_oe_n,
	// Device status
	input wire logic [2:0] protect_level_bits,
	input wire logic       busy_flag,
	input wire logic       write_permit_latch,
	input wire logic       asleep
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	a_desel_quiet_out: assert property (
		cs_n && $past(cs_n) |-> miso_oe_n)
		else $error("data out driven while deselected");
	a_busy_no_read: assert property (busy_flag |-> miso_oe_n)
		else $error("read data driven during a busy cycle");
	a_sleep_no_read: assert property (asleep |-> miso_oe_n)
		else $error("read data driven while asleep");
	a_drive_start_ok: assert property (
		$fell(miso_oe_n) |-> !cs_n && !busy_flag && !asleep)
		else $error("data out started outside a read");
	a_busy_after_rise: assert property (
		$rose(busy_flag) |-> cs_n && $past(cs_n, 2))
		else $error("busy began without a select rise");
	a_busy_has_permit: assert property (
		$rose(busy_flag) |-> $past(write_permit_latch))
		else $error("busy cycle began without the permit latch");
	a_busy_bounded_end: assert property (
		$rose(busy_flag) |-> ##[1:700] !busy_flag)
		else $error("busy cycle did not end");
	a_permit_clear_end: assert property (
		$fell(busy_flag) |-> !write_permit_latch)
		else $error("permit latch still set after cycle");
	a_permit_set_idle: assert property (
		$rose(write_permit_latch) |-> cs_n && !busy_flag && !asleep)
		else $error("permit latch set at a wrong moment");
	a_sleep_when_idle: assert property (
		$rose(asleep) |-> cs_n && !busy_flag)
		else $error("sleep entered during a frame or cycle");
	a_clock_idle_low: assert property (
		cs_n && $past(cs_n) |-> !sclk)
		else $error("link clock running while deselected");
endmodule

// ### tb_serial_flash_cmd_engine.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_serial_flash_cmd_engine;
	import sfe_pkg::*;
	logic        mclk, nrst, cmd_valid, cmd_ready, wr_take, rd_valid, done;
	logic        busy_flag, write_permit_latch, asleep;
	logic [7:0]  cmd_op, wr_data, rd_data, mem [512];
	logic [23:0] cmd_addr;
	logic [2:0]  cmd_hdr, prot;
	logic [15:0] cmd_wlen, cmd_rlen;
	logic [7:0]  exp_q [$];
	logic [7:0]  wq [$];
	int          num_errors = 0;
	int          n_tests = 0;
	bit          quick = 1'b0;

	sfe_link_if link ();
	sfe_device #(.MEM_AW(9), .SECT_AW(6), .PROG_WAIT(200), .ERASE_WAIT(2),
		.SLEEP_DELAY(2)) sfe_device_inst (.mclk(mclk), .nrst(nrst),
		.link(link.dev), .protect_level_bits(prot), .busy_flag(busy_flag),
		.write_permit_latch(write_permit_latch), .asleep(asleep));
	sfe_host sfe_host_inst (.mclk(mclk), .nrst(nrst), .link(link.hst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_hdr(cmd_hdr), .cmd_wlen(cmd_wlen),
		.cmd_rlen(cmd_rlen), .wr_data(wr_data), .wr_take(wr_take),
		.rd_data(rd_data), .rd_valid(rd_valid), .done(done));
	sfe_checker sfe_checker_inst (.mclk(mclk), .nrst(nrst),
		.cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
		.miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n),
		.protect_level_bits(prot), .busy_flag(busy_flag),
		.write_permit_latch(write_permit_latch), .asleep(asleep));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ****************************************
	// Write data supply and read monitor
	// ****************************************
	always @(negedge mclk) wr_data <= (wq.size() != 0) ? wq[0] : 8'h00;
	always @(posedge mclk) begin : mon
		logic [7:0] e;
		if (wr_take === 1'b1 && wq.size() != 0) void'(wq.pop_front());
		if (rd_valid === 1'b1) begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
			`CHK(rd_data, e)
		end
	end

	task automatic test_done();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [23:0] a,
		input logic [2:0] h, input int w, input int r);
		int t;
		@(negedge mclk);
		cmd_op = op;
		cmd_addr = a;
		cmd_hdr = h;
		cmd_wlen = 16'(w);
		cmd_rlen = 16'(r);
		cmd_valid = 1'b1;
		do @(posedge mclk); while (cmd_ready !== 1'b1);
		@(negedge mclk);
		cmd_valid = 1'b0;
		t = 0;
		while (done !== 1'b1 && t < 20000) begin
			@(negedge mclk);
			t++;
		end
		`CHK(done, 1'b1)
		repeat (8) @(negedge mclk);
		t = 0;
		while (!quick && busy_flag !== 1'b0 && t < 2000) begin
			@(negedge mclk);
			t++;
		end
		if (!quick)
			`CHK(busy_flag, 1'b0)
	endtask

	task automatic unl();
		cmd(OP_UNLOCK, 24'h0, HDR_NONE, 0, 0);
	endtask

	task automatic rd(input logic [23:0] a, input int n, input bit ok);
		for (int i = 0; i < n; i++)
			exp_q.push_back(ok ? mem[9'(a + i)] : 8'hff);
		cmd(OP_FAST_READ, a, HDR_FAST, 0, n);
	endtask

	// Only the last 256 bytes land, wrapping in the page; bits only clear
	task automatic pw(input logic [23:0] a, input int n, input bit ok);
		logic [7:0] d;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			wq.push_back(d);
			if (ok && i + 256 >= n)
				mem[{a[8], 8'(a[7:0] + i)}] &= d;
		end
		cmd(OP_PAGE_WRITE, a, HDR_ADDR, n, 0);
	endtask

	initial begin
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 8'h00;
		cmd_addr = 24'h0;
		cmd_hdr = 3'h0;
		cmd_wlen = 16'h0;
		cmd_rlen = 16'h0;
		prot = 3'h0;
		void'($urandom(78));
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		`CHK(write_permit_latch, 1'b0)
		unl();
		`CHK(write_permit_latch, 1'b1)
		cmd(OP_WHOLE_CLEAR, 24'h0, HDR_NONE, 0, 0);
		`CHK(write_permit_latch, 1'b0)
		foreach (mem[i]) mem[i] = ERASED;
		rd(24'h0001fe, 3, 1);
		unl();
		pw(24'hf800fe, 3, 1);
		rd(24'h0001ff, 3, 1);
		rd(24'h0000fd, 3, 1);
		unl();
		pw(24'h0000fe, 1, 1);
		rd(24'h0000fe, 1, 1);
		pw(24'h000010, 1, 0);
		rd(24'h000010, 1, 1);
		unl();
		quick = 1'b1;
		pw(24'h000020, 1, 1);
		quick = 1'b0;
		rd(24'h000020, 1, 0);
		rd(24'h000020, 1, 1);
		unl();
		cmd(OP_PAGE_WRITE, 24'h30, HDR_ADDR, 0, 0);
		`CHK(write_permit_latch, 1'b1)
		cmd(OP_WHOLE_CLEAR, 24'h0, HDR_ADDR, 0, 0);
		`CHK(write_permit_latch, 1'b1)
		cmd(OP_ZONE_CLEAR, 24'h5, HDR_NONE, 0, 0);
		`CHK(write_permit_latch, 1'b1)
		prot = 3'h1;
		pw(24'h0001c4, 1, 0);
		`CHK(write_permit_latch, 1'b1)
		cmd(OP_ZONE_CLEAR, 24'h1c4, HDR_ADDR, 0, 0);
		`CHK(write_permit_latch, 1'b1)
		cmd(OP_WHOLE_CLEAR, 24'h0, HDR_NONE, 0, 0);
		`CHK(write_permit_latch, 1'b1)
		prot = 3'h0;
		cmd(OP_ZONE_CLEAR, 24'h000005, HDR_ADDR, 0, 0);
		`CHK(write_permit_latch, 1'b0)
		for (int i = 0; i < 64; i++) mem[i] = ERASED;
		rd(24'h00001f, 2, 1);
		unl();
		pw(24'h000000, 258, 1);
		rd(24'h000000, 3, 1);
		cmd(OP_SLEEP, 24'h0, HDR_ADDR, 0, 0);
		`CHK(asleep, 1'b0)
		cmd(OP_SLEEP, 24'h0, HDR_NONE, 0, 0);
		`CHK(asleep, 1'b1)
		unl();
		`CHK(write_permit_latch, 1'b0)
		rd(24'h000000, 1, 0);
		cmd(OP_WAKE, 24'h0, HDR_NONE, 0, 0);
		`CHK(asleep, 1'b0)
		test_done();
	end

	initial begin
		repeat (60000) @(posedge mclk);
		num_errors++;
		$display("[FAIL] %0t run did not finish", $time);
		test_done();
	end
endmodule
